// ===== test/dtc_pin_model.sv
`timescale 1ns/100ps
module dtc_pin_model (
   input wire logic clk,
   output logic [1:0] count_pin = 2'b11,
   output logic [1:0] gate_pin = 2'b11
);
   // Each level is held for two peripheral cycles at standard speed.
   localparam int HOLD = 24;
   task automatic pulses(input int k, input int n);
      repeat (n) begin
         count_pin[k] <= 1'b0;
         repeat (HOLD) @(posedge clk);
         count_pin[k] <= 1'b1;
         repeat (HOLD) @(posedge clk);
      end
   endtask
   task automatic gate(input int k, input logic v);
      gate_pin[k] <= v;
      @(posedge clk);
   endtask
endmodule

// ===== test/tb_dual_timer_counter.sv
`timescale 1ns/100ps
`include "dtc_params.svh"
module tb_dual_timer_counter;
   logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rv;
   logic pready, pslverr, irq_req_0, irq_req_1, baud_tick;
   logic irq_ack_0 = 0, irq_ack_1 = 0;
   wire logic [1:0] cp, gp;
   logic [11:0] ad [7] = '{`DTC_ADDR_CTRL, `DTC_ADDR_MODE, `DTC_ADDR_LO0,
      `DTC_ADDR_HI0, `DTC_ADDR_LO1, `DTC_ADDR_HI1, `DTC_ADDR_SPEED};
   logic [64:0] q [$];
   logic [64:0] e;
   int num_errors = 0, compares = 0, seed = 32'h5c92b46e, n, c;
   wire logic [2:0] flg = {baud_tick, irq_req_1, irq_req_0};
   always #20 clk = ~clk;
   dtc_dual_timer dtc_dual_timer_i (.clk, .rst_n, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .count_pin_0(cp[0]),
      .count_pin_1(cp[1]), .gate_pin_0(gp[0]), .gate_pin_1(gp[1]),
      .irq_ack_0, .irq_ack_1, .irq_req_0, .irq_req_1, .baud_tick);
   dtc_pin_model dtc_pin_model_i (.clk, .count_pin(cp), .gate_pin(gp));
   task chk(input string nm, input logic [32:0] got, input logic [32:0] ex);
      compares++;
      if (got !== ex) begin
         $display("FAIL %s expected %h seen %h", nm, ex, got);
         num_errors++;
      end
   endtask
   task report_and_stop;
      $display("Compares %0d mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      input logic [31:0] m, input logic er);
      int k;
      k = 0;
      @(posedge clk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      if (!w) q.push_back({er, m, d});
      @(posedge clk);
      penable <= 1;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      rv = prdata;
      psel <= 0;
      penable <= 0;
      if (k >= 20) begin
         chk("pready", pready, 1);
         report_and_stop;
      end
   endtask
   task wr(input int i, input logic [7:0] d);
      apb(1, ad[i], {24'h0, d}, '0, 0);
   endtask
   task rd(input int i, input logic [7:0] d, input logic [7:0] m);
      apb(0, ad[i], {24'h0, d}, {24'hffffff, m}, 0);
   endtask
   task wt(input int k);
      int j;
      j = 0;
      while (flg[k] !== 1'b1 && j < 60) begin
         @(posedge clk);
         #1;
         j++;
      end
      chk("flag", flg[k], 1);
      if (j >= 60) report_and_stop;
   endtask
   task ack(input int k);
      if (k == 0) irq_ack_0 <= 1;
      else irq_ack_1 <= 1;
      @(posedge clk);
      irq_ack_0 <= 0;
      irq_ack_1 <= 0;
      @(posedge clk);
      #1;
      chk("flag", flg[k], 0);
   endtask
   // Read results are compared against the oldest queued note.
   always @(posedge clk) begin
      if (psel && penable && pready && !pwrite) begin
         e = q.pop_front();
         chk("prdata", {pslverr, prdata & e[63:32]}, {e[64], e[31:0] & e[63:32]});
      end
   end
   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1;
      for (int i = 0; i < 7; i++) rd(i, 8'h00, 8'hff);
      apb(0, 12'h01c, '0, '1, 1);
      for (int s = 1; s >= 0; s--) begin
         wr(6, s[7:0]);
         wr(1, 8'h01);
         wr(2, 8'h40);
         wr(0, 8'h10);
         rd(2, 8'h40, 8'hf0);
         c = rv;
         repeat (117) @(posedge clk);
         rd(2, 8'(c + (s ? 20 : 10)), 8'hff);
         wr(0, 8'h00);
      end
      wr(2, 8'hfe);
      wr(3, 8'hff);
      wr(0, 8'h10);
      wt(0);
      rd(3, 8'h00, 8'hff);
      ack(0);
      wr(0, 8'h00);
      wr(1, 8'h02);
      wr(3, 8'hfd);
      wr(2, 8'hfd);
      wr(0, 8'h10);
      wt(0);
      rd(3, 8'hfd, 8'hff);
      rd(2, 8'hfc, 8'hfc);
      wr(3, 8'h80);
      ack(0);
      wt(0);
      rd(2, 8'h80, 8'hf8);
      wr(0, 8'h00);
      ack(0);
      wr(1, 8'h00);
      wr(3, 8'h00);
      wr(2, 8'hff);
      wr(0, 8'h10);
      repeat (13) @(posedge clk);
      rd(3, 8'h01, 8'hff);
      rd(2, 8'he0, 8'he0);
      wr(0, 8'h00);
      wr(2, 8'h00);
      wr(1, 8'h05);
      wr(0, 8'h10);
      n = 1 + ($unsigned($random(seed)) % 6);
      dtc_pin_model_i.pulses(0, n);
      rd(2, n[7:0], 8'hff);
      wr(0, 8'h00);
      wr(1, 8'hd0);
      wr(0, 8'h40);
      dtc_pin_model_i.gate(1, 0);
      dtc_pin_model_i.pulses(1, 2);
      rd(4, 8'h00, 8'hff);
      dtc_pin_model_i.gate(1, 1);
      dtc_pin_model_i.pulses(1, 3);
      rd(4, 8'h03, 8'hff);
      wr(0, 8'h00);
      wr(3, 8'hfe);
      wr(4, 8'h33);
      wr(1, 8'h33);
      wr(0, 8'h40);
      wt(1);
      rd(4, 8'h33, 8'hff);
      ack(1);
      wr(5, 8'hff);
      wr(4, 8'hff);
      wr(1, 8'h23);
      c = 0;
      for (int i = 0; i < 120; i++) begin
         @(posedge clk);
         #1;
         c += baud_tick;
      end
      chk("baud_tick", 33'(c), 33'd10);
      @(posedge clk);
      rst_n <= 0;
      repeat (2) @(posedge clk);
      rst_n <= 1;
      rd(0, 8'h00, 8'hff);
      rd(1, 8'h00, 8'hff);
      rd(4, 8'h00, 8'hff);
      report_and_stop;
   end
endmodule

// ===== verilog/dtc_dual_timer.sv
// Behaviour
// (R1) Running timer counts low byte, carries into high byte, high overflow sets flag.
// (R2) Setting the run bit starts from current contents without clearing counts.
// (R3) Software reads counts anytime but stops the timer before presetting.
// (R4) Timer operation advances once per peripheral cycle of six peripheral clocks.
// (R5) Counter operation counts a high sample followed by a low sample.
// (R6) External count source holds each level at least one peripheral cycle.
// (R7) Source select picks peripheral cycle ticks or count pin falls.
// (R8) Without gating the run bit alone enables; with gating the pin too.
// (R9) With gating enabled, count only while gate pin high and run set.
// (R10) Rollover from all ones to zeros sets the overflow flag and requests.
// (R11) Servicing the interrupt clears the matching overflow flag in hardware.
// (R12) Mode 0: high byte counts, fed by five-bit low-byte prescaler.
// (R13) Mode 2: low byte counts, on overflow sets flag, reloads from high.
// (R14) In auto-reload the high byte may be written anytime for next reload.
// (R15) Timer 0 mode 3: low byte normal, high byte uses timer 1 controls.
// (R16) Timer 1 in mode 3 stops and keeps its count.
// (R17) Timer 0 uses low mode bits and control bits 0,1,4,5; timer 1 others. Here timer 0 uses control bits 4,5 only; bits 0,1 are unused.
// (R18) Mode field: 00 thirteen-bit, 01 sixteen-bit, 10 reload, 11 split/halt.
// (R19) Timer 1 overflow is offered as the serial baud clock.
// (R20) Software stops a timer before changing its mode or source.
// (R21) With timer 0 split, timer 1 is started and stopped via mode 3.
// (R22) Reset clears counts, run bits, overflow flags and mode fields.
//
// Design decisions made here: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
`include "dtc_params.svh"
module dtc_dual_timer (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic count_pin_0,
   input wire logic count_pin_1,
   input wire logic gate_pin_0,
   input wire logic gate_pin_1,
   input wire logic irq_ack_0,
   input wire logic irq_ack_1,
   output logic irq_req_0,
   output logic irq_req_1,
   output logic baud_tick
);
   dtc_pkg::dtc_top_t q;
   dtc_pkg::dtc_top_t n;

   logic periph_tick;
   logic t0_split;
   logic wr_any;
   logic hit;
   logic [31:0] rmux;
   logic [1:0] count_pin;
   logic [1:0] gate_pin;
   logic [1:0] irq_ack;
   logic [1:0] fall;
   logic [1:0] gate_lvl;
   logic [1:0] en;
   logic [1:0] inc;
   logic [1:0] hw_set;
   logic [1:0][1:0] mode_f;

   assign count_pin = {count_pin_1, count_pin_0};
   assign gate_pin = {gate_pin_1, gate_pin_0};
   assign irq_ack = {irq_ack_1, irq_ack_0};
   assign periph_tick = (q.pre == '0);
   assign t0_split = (mode_f[0] == dtc_pkg::DTC_M3);
   assign wr_any = psel & penable & pwrite;

   // One step of a timer in modes 0 to 2; bit 16 is the overflow.
   function automatic logic [16:0] step(input logic [1:0] m,
                                         input logic [7:0] l,
                                         input logic [7:0] h);
      logic [16:0] r;
      r = {1'b0, h, l};
      case (dtc_pkg::dtc_mode_t'(m))
         dtc_pkg::DTC_M13: begin
            r[4:0] = l[4:0] + 5'h01; // [R12]
            if (l[4:0] == `DTC_LO5_MAX) begin
               r[15:8] = h + 8'h01; // [R12]
               r[16] = (h == `DTC_BYTE_MAX);
            end
         end
         dtc_pkg::DTC_M16: begin
            r = {1'b0, h, l} + 17'h00001; // [R1]
         end
         dtc_pkg::DTC_M8R: begin
            if (l == `DTC_BYTE_MAX) begin
               r = {1'b1, h, h}; // [R13]
            end else begin
               r[7:0] = l + 8'h01;
            end
         end
         default: begin
         end
      endcase
      return r;
   endfunction

   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : gen_tmr
         logic src_sel;
         logic gate_en;
         logic run_src;
         dtc_smp_if sif ();
         assign sif.tick = periph_tick;
         assign fall[g] = sif.fall;
         assign gate_lvl[g] = sif.gate;
         dtc_sampler u_smp (
            .clk(clk),
            .rst_n(rst_n),
            .count_pin(count_pin[g]),
            .gate_pin(gate_pin[g]),
            .bus(sif.smp)
         );
         assign mode_f[g] = q.mode[g*`DTC_T1_BASE +: 2]; // [R17] [R18]
         assign src_sel = q.mode[g*`DTC_T1_BASE + `DTC_SRC_BIT];
         assign gate_en = q.mode[g*`DTC_T1_BASE + `DTC_GATE_BIT];
         // While timer 0 is split, timer 1 loses its run bit and runs free.
         assign run_src = q.run[g] | ((g == 1) & t0_split);
         assign en[g] = run_src & (~gate_en | gate_lvl[g]); // [R8] [R9]
         assign inc[g] = en[g] & (src_sel ? fall[g] : periph_tick); // [R7]
      end
   endgenerate

   always_comb begin
      hit = 1'b1;
      rmux = 32'h00000000;
      case (paddr)
         `DTC_ADDR_CTRL: begin
            rmux[`DTC_OVF1_BIT] = q.ovf[1];
            rmux[`DTC_RUN1_BIT] = q.run[1];
            rmux[`DTC_OVF0_BIT] = q.ovf[0];
            rmux[`DTC_RUN0_BIT] = q.run[0];
         end
         `DTC_ADDR_MODE: rmux[7:0] = q.mode;
         `DTC_ADDR_LO0: rmux[7:0] = q.lo[0];
         `DTC_ADDR_HI0: rmux[7:0] = q.hi[0];
         `DTC_ADDR_LO1: rmux[7:0] = q.lo[1];
         `DTC_ADDR_HI1: rmux[7:0] = q.hi[1];
         `DTC_ADDR_SPEED: rmux[`DTC_SPEED_BIT] = q.dbl;
         default: hit = 1'b0;
      endcase
   end

   always_comb begin
      logic [16:0] s0;
      logic [16:0] s1;
      logic wr;
      s0 = 17'h00000;
      s1 = 17'h00000;
      wr = wr_any & hit;
      n = q;
      n.baud = 1'b0;
      hw_set = 2'b00;
      // Prescaler gives one tick per peripheral cycle.
      if (periph_tick) begin
         n.pre = q.dbl ?
            `DTC_PRE_W'(`DTC_PCLK_PER_CYC * `DTC_CLK_PER_PCLK_X2 - 1) :
            `DTC_PRE_W'(`DTC_PCLK_PER_CYC * `DTC_CLK_PER_PCLK_STD - 1);
      end else begin
         n.pre = q.pre - 4'h1; // [R4]
      end
      if (t0_split) begin
         if (inc[0]) begin
            n.lo[0] = q.lo[0] + 8'h01; // [R15]
            hw_set[0] = (q.lo[0] == `DTC_BYTE_MAX);
         end
         if (q.run[1] && periph_tick) begin
            n.hi[0] = q.hi[0] + 8'h01; // [R15]
            hw_set[1] = (q.hi[0] == `DTC_BYTE_MAX);
         end
      end else if (inc[0]) begin
         s0 = step(mode_f[0], q.lo[0], q.hi[0]);
         n.lo[0] = s0[7:0];
         n.hi[0] = s0[15:8];
         hw_set[0] = s0[16]; // [R10]
      end
      // Mode 3 on timer 1 holds its count.
      if (inc[1] && mode_f[1] != dtc_pkg::DTC_M3) begin // [R16]
         s1 = step(mode_f[1], q.lo[1], q.hi[1]);
         n.lo[1] = s1[7:0];
         n.hi[1] = s1[15:8];
         n.baud = s1[16]; // [R19]
         if (!t0_split) begin
            hw_set[1] = s1[16]; // [R10]
         end
      end
      for (int i = 0; i < 2; i++) begin
         if (irq_ack[i]) begin
            n.ovf[i] = 1'b0; // [R11]
         end
      end
      if (wr) begin
         case (paddr)
            `DTC_ADDR_CTRL: begin
               n.run[0] = pwdata[`DTC_RUN0_BIT]; // [R2] [R17]
               n.run[1] = pwdata[`DTC_RUN1_BIT];
               n.ovf[0] = pwdata[`DTC_OVF0_BIT];
               n.ovf[1] = pwdata[`DTC_OVF1_BIT];
            end
            `DTC_ADDR_MODE: n.mode = pwdata[7:0];
            `DTC_ADDR_LO0: n.lo[0] = pwdata[7:0];
            `DTC_ADDR_HI0: n.hi[0] = pwdata[7:0]; // [R14]
            `DTC_ADDR_LO1: n.lo[1] = pwdata[7:0];
            `DTC_ADDR_HI1: n.hi[1] = pwdata[7:0]; // [R14]
            `DTC_ADDR_SPEED: n.dbl = pwdata[`DTC_SPEED_BIT];
            default: begin
            end
         endcase
      end
      // A hardware overflow beats any clear in the same cycle.
      for (int i = 0; i < 2; i++) begin
         if (hw_set[i]) begin
            n.ovf[i] = 1'b1; // [R10]
         end
      end
      if (psel && !penable) begin
         n.rdata = rmux;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0; // [R22]
      end else begin
         q <= n;
      end
   end

   assign prdata = q.rdata;
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~hit;
   assign irq_req_0 = q.ovf[0];
   assign irq_req_1 = q.ovf[1];
   assign baud_tick = q.baud;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   sequence roll_m2_s;
      mode_f[0] == dtc_pkg::DTC_M8R && inc[0] &&
         q.lo[0] == `DTC_BYTE_MAX && !wr_any;
   endsequence

   sequence reload_s;
      q.lo[0] == $past(q.hi[0]) && q.ovf[0] && $stable(q.hi[0]);
   endsequence

   run_start_a: assert property ($rose(q.run[0]) |->
      q.lo[0] == $past(q.lo[0]) && q.hi[0] == $past(q.hi[0])) // [R2]
      else $error("run start altered the count");

   tick_space_a: assert property (periph_tick |=> !periph_tick [*5]) // [R4]
      else $error("peripheral tick faster than six clocks");

   tick_std_a: assert property (periph_tick && !q.dbl |=>
      !periph_tick [*8]) // [R4]
      else $error("standard peripheral tick too fast");

   gate_hold_a: assert property (q.mode[`DTC_GATE_BIT] && !gate_lvl[0] &&
      !wr_any |=> q.lo[0] == $past(q.lo[0])) // [R9]
      else $error("timer 0 counted with gate low");

   gate_hold1_a: assert property (q.mode[`DTC_T1_BASE + `DTC_GATE_BIT] &&
      !gate_lvl[1] && !wr_any |=> q.lo[1] == $past(q.lo[1])) // [R9]
      else $error("timer 1 counted with gate low");

   flag_set_a: assert property (mode_f[0] == dtc_pkg::DTC_M16 && inc[0] &&
      {q.hi[0], q.lo[0]} == 16'hffff && !wr_any |=>
      q.ovf[0] && {q.hi[0], q.lo[0]} == 16'h0000) // [R10]
      else $error("sixteen-bit rollover missed the flag");

   ack_clr_a: assert property (irq_ack[0] && !hw_set[0] && !wr_any |=>
      !q.ovf[0]) // [R11]
      else $error("service did not clear timer 0 flag");

   ack_clr1_a: assert property (irq_ack[1] && !hw_set[1] && !wr_any |=>
      !q.ovf[1]) // [R11]
      else $error("service did not clear timer 1 flag");

   reload_a: assert property (roll_m2_s |=> reload_s) // [R13]
      else $error("auto reload failed");

   pre_carry_a: assert property (mode_f[0] == dtc_pkg::DTC_M13 && inc[0] &&
      q.lo[0][4:0] == `DTC_LO5_MAX && !wr_any |=>
      q.lo[0][4:0] == 5'h00 &&
      q.hi[0] == $past(q.hi[0]) + 8'h01) // [R12]
      else $error("prescaler carry wrong");

   split_hi_a: assert property (t0_split && q.run[1] && periph_tick &&
      q.hi[0] == `DTC_BYTE_MAX && !wr_any |=>
      q.ovf[1] && q.hi[0] == `DTC_BYTE_RST) // [R15]
      else $error("split high byte overflow wrong");

   halt_a: assert property (mode_f[1] == dtc_pkg::DTC_M3 && !wr_any |=>
      $stable(q.lo[1]) && $stable(q.hi[1])) // [R16]
      else $error("timer 1 moved in hold mode");
endmodule

// ===== verilog/dtc_params.svh
`ifndef DTC_PARAMS_SVH
`define DTC_PARAMS_SVH

// Register byte addresses on the APB.
`define DTC_ADDR_CTRL 12'h000
`define DTC_ADDR_MODE 12'h004
`define DTC_ADDR_LO0 12'h008
`define DTC_ADDR_HI0 12'h00c
`define DTC_ADDR_LO1 12'h010
`define DTC_ADDR_HI1 12'h014
`define DTC_ADDR_SPEED 12'h018

// Bit positions in timer_control_reg.
`define DTC_RUN0_BIT 4
`define DTC_OVF0_BIT 5
`define DTC_RUN1_BIT 6
`define DTC_OVF1_BIT 7

// Field positions in mode_control_reg, per timer from its base, and the speed register bit.
`define DTC_T1_BASE 4
`define DTC_SRC_BIT 2
`define DTC_GATE_BIT 3
`define DTC_SPEED_BIT 0

// Reset value and limits of the count bytes.
`define DTC_BYTE_RST 8'h00
`define DTC_BYTE_MAX 8'hff
`define DTC_LO5_MAX 5'h1f

// Peripheral cycle timing: peripheral clocks per cycle, clk periods per peripheral clock, prescaler width.
`define DTC_PCLK_PER_CYC 6
`define DTC_CLK_PER_PCLK_STD 2
`define DTC_CLK_PER_PCLK_X2 1
`define DTC_PRE_W 4

`endif

// ===== verilog/dtc_pkg.sv
package dtc_pkg;

   typedef enum logic [1:0] {
      DTC_M13,
      DTC_M16,
      DTC_M8R,
      DTC_M3
   } dtc_mode_t;

   typedef struct packed {
      logic [1:0][7:0] lo;
      logic [1:0][7:0] hi;
      logic [1:0] run;
      logic [1:0] ovf;
      logic [7:0] mode;
      logic dbl;
      logic [3:0] pre;
      logic [31:0] rdata;
      logic baud;
   } dtc_top_t;

   typedef struct packed {
      logic cnt_m;
      logic cnt_s;
      logic gate_m;
      logic gate_s;
      logic last;
      logic fall;
   } dtc_smp_t;

endpackage

// ===== verilog/dtc_sampler.sv
`timescale 1ns/100ps
module dtc_sampler (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic count_pin,
   input wire logic gate_pin,
   dtc_smp_if.smp bus
);
   dtc_pkg::dtc_smp_t q;
   dtc_pkg::dtc_smp_t n;

   // The count level is judged once per peripheral cycle only.
   always_comb begin
      n = q;
      n.cnt_m = count_pin;
      n.cnt_s = q.cnt_m;
      n.gate_m = gate_pin;
      n.gate_s = q.gate_m;
      n.fall = bus.tick & q.last & ~q.cnt_s; // [R5]
      if (bus.tick) begin
         n.last = q.cnt_s; // [R5]
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

   assign bus.fall = q.fall;
   assign bus.gate = q.gate_s;

   fall_space_a: assert property (@(posedge clk) disable iff (!rst_n)
      q.fall |=> !q.fall [*8]) // [R5]
      else $error("count events closer than two peripheral cycles");

   fall_cause_a: assert property (@(posedge clk) disable iff (!rst_n)
      q.fall |-> $past(bus.tick) && !q.last) // [R5]
      else $error("count event without high then low sample");
endmodule

// ===== verilog/dtc_smp_if.sv
`timescale 1ns/100ps
interface dtc_smp_if;
   logic tick;
   logic fall;
   logic gate;
   modport smp (input tick, output fall, output gate);
   modport top (output tick, input fall, input gate);
endinterface
